// ---- core/isoch_rx_cfg.svh ----
// Purpose: offsets, field positions, reset values and bus answers of the isochronous context registers
// Assumes: 12-bit byte addresses on the register bus
// Notes:   definitions only
`ifndef ISOCH_RX_CFG_SVH
`define ISOCH_RX_CFG_SVH

`define TX_CONTEXTS        8
`define RX_CONTEXTS        4
`define TXPTR_BASE         12'h20c
`define TXPTR_STRIDE       12'h010
`define RXCTL_SET_BASE     12'h400
`define RXCTL_CLR_BASE     12'h404
`define RXCTL_STRIDE       12'h020
`define RXCTL_SPAN         12'h080

`define BIT_PACK_FILL      31
`define BIT_HEADER_KEEP    30
`define BIT_START_ON_CYCLE 29
`define BIT_MULTICHANNEL   28
`define BIT_SPLIT          27
`define BIT_RUN            15
`define BIT_ACTIVE         10

`define TXPTR_RESET        32'h0000_0000
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ---- core/isoch_rx_pkg.sv ----
// Purpose: types shared by the isochronous receive context logic
// Assumes: nothing beyond the cfg header
// Notes:   constants live in the cfg header, types here
package isoch_rx_pkg;

	typedef struct packed {
		logic pack_fill;
		logic header_keep;
		logic start_on_cycle;
		logic multichannel;
		logic split;
		logic run;
		logic active;
	} rx_ctrl_t;

	typedef struct packed {
		logic        set_en;
		logic        clr_en;
		logic [31:0] bits;
	} ctrl_write_t;

	typedef struct packed {
		logic [5:0]  channel;
		logic [15:0] status;
	} rx_pkt_t;

	typedef struct packed {
		logic [1:0]  ctx;
		logic        keep_header;
		logic        pack_fill;
		logic        split;
		logic [31:0] trailer;
	} rx_deliver_t;

	typedef struct packed {
		logic       hit_tx;
		logic       hit_rx;
		logic       clr;
		logic [2:0] idx;
	} reg_decode_t;

endpackage : isoch_rx_pkg

// ---- core/rx_ctx_ctrl.sv ----
// Purpose: control bits of one isochronous receive context
// Assumes: one write strobe per cycle, set or clear
// Notes:   active follows run and the start-on-cycle condition
`timescale 1ns/1ps
`default_nettype none
`include "isoch_rx_cfg.svh"

module rx_ctx_ctrl (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// software write
	input  wire isoch_rx_pkg::ctrl_write_t wr,
	// cycle-start events
	input  wire logic                      cyc_start,
	input  wire logic [12:0]               cyc_number,
	input  wire logic [12:0]               match_cycle,
	// state
	output var  isoch_rx_pkg::rx_ctrl_t    ctrl
);

	isoch_rx_pkg::rx_ctrl_t ctrl_reg;
	isoch_rx_pkg::rx_ctrl_t ctrl_next;

	function automatic logic apply_bit(input logic cur, input logic s, input logic c);
		return (cur | s) & ~c;
	endfunction : apply_bit

	wire [31:0] set_v     = wr.set_en ? wr.bits : 32'h0000_0000;
	wire [31:0] clr_v     = wr.clr_en ? wr.bits : 32'h0000_0000;
	wire        busy      = ctrl_reg.run | ctrl_reg.active;
	wire        cycle_hit = cyc_start & (cyc_number == match_cycle);
	wire        run_next  = apply_bit(ctrl_reg.run, set_v[`BIT_RUN], clr_v[`BIT_RUN]);
	wire        split_next = busy ? ctrl_reg.split :
		apply_bit(ctrl_reg.split, set_v[`BIT_SPLIT], clr_v[`BIT_SPLIT]);
	// start is taken from the present run so a context never starts in the cycle software sets run
	wire        active_next = ctrl_reg.run & run_next &
		(ctrl_reg.active | ~ctrl_reg.start_on_cycle | cycle_hit);

	always_comb begin
		ctrl_next              = ctrl_reg;
		ctrl_next.run          = run_next;
		ctrl_next.active       = active_next;
		ctrl_next.split        = split_next;
		ctrl_next.header_keep  = apply_bit(ctrl_reg.header_keep, set_v[`BIT_HEADER_KEEP], clr_v[`BIT_HEADER_KEEP]);
		ctrl_next.pack_fill    = split_next ? 1'b0 :
			apply_bit(ctrl_reg.pack_fill, set_v[`BIT_PACK_FILL], clr_v[`BIT_PACK_FILL]);
		ctrl_next.multichannel = split_next ? 1'b0 :
			apply_bit(ctrl_reg.multichannel, set_v[`BIT_MULTICHANNEL], clr_v[`BIT_MULTICHANNEL]);
		// hardware clear wins here: an active context must not re-arm a cycle match
		ctrl_next.start_on_cycle = active_next ? 1'b0 :
			apply_bit(ctrl_reg.start_on_cycle, set_v[`BIT_START_ON_CYCLE], clr_v[`BIT_START_ON_CYCLE]);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	assign ctrl = ctrl_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_split_locked: assert property (busy |=> ctrl_reg.split == $past(ctrl_reg.split))
		else $error("split mode changed while context busy");
	a_split_forces: assert property (ctrl_reg.split |-> !ctrl_reg.pack_fill && !ctrl_reg.multichannel)
		else $error("split mode left pack or multichannel set");
	a_soc_cleared: assert property (ctrl_reg.active |-> !ctrl_reg.start_on_cycle)
		else $error("start on cycle still set while active");
	a_run_sw_only: assert property (!wr.set_en && !wr.clr_en |=> $stable(ctrl_reg.run))
		else $error("run changed without a software write");
	a_start_waits: assert property (ctrl_reg.run && ctrl_reg.start_on_cycle && !ctrl_reg.active
		&& !cycle_hit |=> !ctrl_reg.active)
		else $error("context started without a cycle match");
	a_start_on_hit: assert property (ctrl_reg.run && run_next && cycle_hit |=> ctrl_reg.active)
		else $error("context missed its start cycle");
	a_active_run: assert property (ctrl_reg.active |-> ctrl_reg.run)
		else $error("active without run");
	c_cycle_start: cover property (ctrl_reg.start_on_cycle ##[1:50] $rose(ctrl_reg.active));
	c_split_set: cover property ($rose(ctrl_reg.split));

endmodule : rx_ctx_ctrl
`default_nettype wire

// ---- core/rx_pkt_route.sv ----
// Purpose: choose the receive context for each packet and describe how it is stored
// Assumes: one packet descriptor per pkt_valid pulse
// Notes:   lowest-numbered accepting context wins
`timescale 1ns/1ps
`default_nettype none

module rx_pkt_route (
	// clock and reset
	input  wire logic                               clk,
	input  wire logic                               rst_n,
	// context state and filters
	input  wire isoch_rx_pkg::rx_ctrl_t [3:0]       ctrl,
	input  wire logic [3:0][5:0]                    match_channel,
	input  wire logic [63:0]                        chan_mask,
	// cycle timer
	input  wire logic                               cyc_start,
	input  wire logic [2:0]                         cyc_seconds,
	input  wire logic [12:0]                        cyc_number,
	// packets in
	input  wire logic                               pkt_valid,
	input  wire isoch_rx_pkg::rx_pkt_t              pkt,
	// packets out
	output logic                                    deliver_valid,
	output var  isoch_rx_pkg::rx_deliver_t          deliver,
	output logic                                    pkt_miss
);

	logic [15:0]               stamp_reg;
	logic                      valid_reg;
	logic                      miss_reg;
	isoch_rx_pkg::rx_deliver_t deliver_reg;
	isoch_rx_pkg::rx_deliver_t deliver_next;
	logic                      hit;
	logic [3:0]                accepts;

	function automatic logic ctx_accepts(input isoch_rx_pkg::rx_ctrl_t c, input logic [5:0] mch,
		input logic [63:0] mask, input logic [5:0] ch);
		// multichannel ignores the match channel and follows the mask only
		return c.active & (c.multichannel ? mask[ch] : (ch == mch));
	endfunction : ctx_accepts

	always_comb begin
		hit          = 1'b0;
		deliver_next = '0;
		for (int i = 3; i >= 0; i--) begin
			accepts[i] = ctx_accepts(ctrl[i], match_channel[i], chan_mask, pkt.channel);
			if (accepts[i]) begin
				hit                      = 1'b1;
				deliver_next.ctx         = 2'(i);
				deliver_next.keep_header = ctrl[i].header_keep;
				deliver_next.pack_fill   = ctrl[i].pack_fill;
				deliver_next.split       = ctrl[i].split;
				deliver_next.trailer     = ctrl[i].header_keep ? {pkt.status, stamp_reg} : 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stamp_reg   <= 16'h0000;
			valid_reg   <= 1'b0;
			miss_reg    <= 1'b0;
			deliver_reg <= '0;
		end else begin
			if (cyc_start) begin
				stamp_reg <= {cyc_seconds, cyc_number};
			end
			valid_reg <= pkt_valid & hit;
			miss_reg  <= pkt_valid & ~hit;
			if (pkt_valid & hit) begin
				deliver_reg <= deliver_next;
			end
		end
	end

	assign deliver_valid = valid_reg;
	assign deliver       = deliver_reg;
	assign pkt_miss      = miss_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_single_chan: assert property (pkt_valid && ctrl[0].active && !ctrl[0].multichannel
		&& pkt.channel == match_channel[0] |=> deliver_valid && deliver.ctx == 2'h0)
		else $error("single channel packet not taken");
	a_multi_mask: assert property (pkt_valid && ctrl[1].active && ctrl[1].multichannel
		&& !chan_mask[pkt.channel] && !accepts[0] && !accepts[2] && !accepts[3] |=> pkt_miss)
		else $error("masked channel accepted in multichannel mode");
	a_strip_header: assert property (deliver_valid && !deliver.keep_header |-> deliver.trailer == 32'h0000_0000)
		else $error("trailer present with header stripped");
	a_trailer_stamp: assert property (pkt_valid && hit && deliver_next.keep_header
		|=> deliver.trailer[15:0] == $past(stamp_reg))
		else $error("trailer timestamp wrong");
	c_multi_pkt: cover property (pkt_valid && ctrl[1].multichannel ##1 deliver_valid);
	c_header_pkt: cover property (deliver_valid && deliver.keep_header);

endmodule : rx_pkt_route
`default_nettype wire

// ---- core/isoch_rx_context_control.sv ----
// Purpose: isochronous context registers behind an AXI4-Lite slave, with receive routing
// Assumes: one clock; packet and cycle inputs synchronous to CLK
// Notes:   registers answer one cycle after both write halves, or after the read address, are held
//
// Notes on behaviour
// - transmit context n pointer reads at 20Ch plus 16n, n 0 to 7.
// - transmit pointer is read-only and readable while the context runs.
// - receive context n control: set at 400h+32n, clear at 404h+32n.
// - pack-fill bit 31 packs packets into full buffers, else one per buffer.
// - header-keep bit 30 keeps header, appends status and 16-bit cycle timestamp.
// - header-keep clear strips the header, storing payload only.
// - start-on-cycle bit 29 delays start until cycle-start number matches.
// - hardware clears start-on-cycle bit 29 once the context is active.
// - multichannel bit 28 accepts every masked channel, ignoring match channel.
// - without multichannel only the match channel is accepted.
// - split bit 27 streams first and second payload parts to separate buffers.
// - split mode forces multichannel and pack-fill bits to zero.
// - writes to split bit 27 are ignored while active or run.
// - reserved bits 26 to 16 read as zero.
// - run bit 15 changes only by software or reset.
// - active bit 10 is one while the context processes descriptors.
`timescale 1ns/1ps
`default_nettype none
`include "isoch_rx_cfg.svh"

module isoch_rx_context_control (
	// clock and reset
	input  wire logic                      CLK,
	input  wire logic                      RSTN,
	// axi4-lite write address and data
	input  wire logic                      AWVALID,
	output logic                           AWREADY,
	input  wire logic [11:0]               AWADDR,
	input  wire logic [2:0]                AWPROT,
	input  wire logic                      WVALID,
	output logic                           WREADY,
	input  wire logic [31:0]               WDATA,
	input  wire logic [3:0]                WSTRB,
	// axi4-lite write response
	output logic                           BVALID,
	input  wire logic                      BREADY,
	output logic [1:0]                     BRESP,
	// axi4-lite read
	input  wire logic                      ARVALID,
	output logic                           ARREADY,
	input  wire logic [11:0]               ARADDR,
	input  wire logic [2:0]                ARPROT,
	output logic                           RVALID,
	input  wire logic                      RREADY,
	output logic [31:0]                    RDATA,
	output logic [1:0]                     RRESP,
	// transmit pointer load from the descriptor engine
	input  wire logic [7:0]                TX_PTR_LOAD,
	input  wire logic [31:0]               TX_PTR_VALUE,
	// receive filters and cycle timer
	input  wire logic [3:0][12:0]          MATCH_CYCLE,
	input  wire logic [3:0][5:0]           MATCH_CHANNEL,
	input  wire logic [63:0]               CHAN_MASK,
	input  wire logic                      CYC_START,
	input  wire logic [2:0]                CYC_SECONDS,
	input  wire logic [12:0]               CYC_NUMBER,
	// received packets
	input  wire logic                      PKT_VALID,
	input  wire isoch_rx_pkg::rx_pkt_t     PKT,
	// storage directions and context state
	output logic                           DELIVER_VALID,
	output var  isoch_rx_pkg::rx_deliver_t DELIVER,
	output logic                           PKT_MISS,
	output var  isoch_rx_pkg::rx_ctrl_t [3:0] RX_CTRL
);

	logic [31:0]            tx_ptr_reg [`TX_CONTEXTS];
	logic                   aw_held_reg;
	logic                   w_held_reg;
	logic [11:0]            awaddr_reg;
	logic [31:0]            wdata_reg;
	logic [3:0]             wstrb_reg;
	logic                   awready_reg;
	logic                   wready_reg;
	logic                   bvalid_reg;
	logic [1:0]             bresp_reg;
	logic                   arready_reg;
	logic                   rvalid_reg;
	logic [31:0]            rdata_reg;
	logic [1:0]             rresp_reg;
	logic                   rd_rx_reg;
	isoch_rx_pkg::rx_ctrl_t [3:0]      ctrl;
	isoch_rx_pkg::ctrl_write_t [3:0]   ctrl_wr;

	function automatic isoch_rx_pkg::reg_decode_t decode(input logic [11:0] a);
		isoch_rx_pkg::reg_decode_t d;
		logic [11:0] tx_off;
		logic [11:0] rx_off;
		d      = '0;
		tx_off = a - `TXPTR_BASE;
		rx_off = a - `RXCTL_SET_BASE;
		// tx pointers sit 16 bytes apart; the gaps belong to other registers not held here
		d.hit_tx = (a >= `TXPTR_BASE) && (tx_off[3:0] == 4'h0) &&
			(tx_off < 12'(`TX_CONTEXTS) * `TXPTR_STRIDE);
		d.hit_rx = (a >= `RXCTL_SET_BASE) && (rx_off < `RXCTL_SPAN) &&
			((rx_off[4:0] == 5'h00) || (rx_off[4:0] == 5'h04));
		d.clr    = rx_off[2];
		d.idx    = d.hit_tx ? tx_off[6:4] : {1'b0, rx_off[6:5]};
		return d;
	endfunction : decode

	function automatic logic [31:0] lane_mask(input logic [3:0] s);
		return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : lane_mask

	function automatic logic [31:0] ctrl_word(input isoch_rx_pkg::rx_ctrl_t c);
		logic [31:0] w;
		w                      = 32'h0000_0000;
		w[`BIT_PACK_FILL]      = c.pack_fill;
		w[`BIT_HEADER_KEEP]    = c.header_keep;
		w[`BIT_START_ON_CYCLE] = c.start_on_cycle;
		w[`BIT_MULTICHANNEL]   = c.multichannel;
		w[`BIT_SPLIT]          = c.split;
		w[`BIT_RUN]            = c.run;
		w[`BIT_ACTIVE]         = c.active;
		return w;
	endfunction : ctrl_word

	// write path
	wire                            do_write   = aw_held_reg & w_held_reg & ~bvalid_reg;
	wire isoch_rx_pkg::reg_decode_t wr_dec     = decode(awaddr_reg);
	wire [31:0]                     wr_bits    = wdata_reg & lane_mask(wstrb_reg);
	wire                            aw_take    = AWVALID & awready_reg;
	wire                            w_take     = WVALID & wready_reg;
	wire                            aw_next    = aw_take | (aw_held_reg & ~do_write);
	wire                            w_next     = w_take | (w_held_reg & ~do_write);
	wire                            bvalid_next = do_write | (bvalid_reg & ~BREADY);
	// only rx control is writable; the tx pointer is read-only
	wire [1:0]                      wr_resp    = wr_dec.hit_rx ? `RESP_OKAY : `RESP_SLVERR;

	// read path
	wire                            ar_take    = ARVALID & arready_reg;
	wire isoch_rx_pkg::reg_decode_t rd_dec     = decode(ARADDR);
	wire                            rvalid_next = ar_take | (rvalid_reg & ~RREADY);
	wire [31:0]                     rd_word    = rd_dec.hit_tx ? tx_ptr_reg[rd_dec.idx] :
		rd_dec.hit_rx ? ctrl_word(ctrl[rd_dec.idx[1:0]]) : 32'h0000_0000;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awaddr_reg  <= 12'h000;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `RESP_OKAY;
		end else begin
			aw_held_reg <= aw_next;
			w_held_reg  <= w_next;
			awready_reg <= ~aw_next & ~bvalid_next;
			wready_reg  <= ~w_next & ~bvalid_next;
			bvalid_reg  <= bvalid_next;
			if (aw_take) begin
				awaddr_reg <= AWADDR;
			end
			if (w_take) begin
				wdata_reg <= WDATA;
				wstrb_reg <= WSTRB;
			end
			if (do_write) begin
				bresp_reg <= wr_resp;
			end
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= `RESP_OKAY;
			rd_rx_reg   <= 1'b0;
		end else begin
			arready_reg <= ~rvalid_next;
			rvalid_reg  <= rvalid_next;
			if (ar_take) begin
				rdata_reg <= rd_word;
				rresp_reg <= (rd_dec.hit_tx | rd_dec.hit_rx) ? `RESP_OKAY : `RESP_SLVERR;
				rd_rx_reg <= rd_dec.hit_rx;
			end
		end
	end

	// pointers load from the fetch engine only; software cannot write them
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			for (int i = 0; i < `TX_CONTEXTS; i++) begin
				tx_ptr_reg[i] <= `TXPTR_RESET;
			end
		end else begin
			for (int i = 0; i < `TX_CONTEXTS; i++) begin
				if (TX_PTR_LOAD[i]) begin
					tx_ptr_reg[i] <= TX_PTR_VALUE;
				end
			end
		end
	end

	for (genvar n = 0; n < `RX_CONTEXTS; n++) begin : g_rx
		wire sel = do_write & wr_dec.hit_rx & (wr_dec.idx[1:0] == 2'(n));
		assign ctrl_wr[n] = '{set_en: sel & ~wr_dec.clr, clr_en: sel & wr_dec.clr, bits: wr_bits};
		rx_ctx_ctrl u_ctx (
			.clk         (CLK),
			.rst_n       (RSTN),
			.wr          (ctrl_wr[n]),
			.cyc_start   (CYC_START),
			.cyc_number  (CYC_NUMBER),
			.match_cycle (MATCH_CYCLE[n]),
			.ctrl        (ctrl[n])
		);
	end

	rx_pkt_route u_route (
		.clk           (CLK),
		.rst_n         (RSTN),
		.ctrl          (ctrl),
		.match_channel (MATCH_CHANNEL),
		.chan_mask     (CHAN_MASK),
		.cyc_start     (CYC_START),
		.cyc_seconds   (CYC_SECONDS),
		.cyc_number    (CYC_NUMBER),
		.pkt_valid     (PKT_VALID),
		.pkt           (PKT),
		.deliver_valid (DELIVER_VALID),
		.deliver       (DELIVER),
		.pkt_miss      (PKT_MISS)
	);

	assign AWREADY = awready_reg;
	assign WREADY  = wready_reg;
	assign BVALID  = bvalid_reg;
	assign BRESP   = bresp_reg;
	assign ARREADY = arready_reg;
	assign RVALID  = rvalid_reg;
	assign RDATA   = rdata_reg;
	assign RRESP   = rresp_reg;
	assign RX_CTRL = ctrl;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);

	a_reserved_zero: assert property (RVALID && rd_rx_reg |-> RDATA[26:16] == 11'h000)
		else $error("reserved control bits read nonzero");
	a_tx_ro_resp: assert property (do_write && wr_dec.hit_tx |=> BVALID && BRESP == `RESP_SLVERR)
		else $error("write to tx pointer not refused");
	a_set_applies: assert property (do_write && wr_dec.hit_rx && !wr_dec.clr && wr_bits[`BIT_HEADER_KEEP]
		|=> ctrl[$past(wr_dec.idx[1:0])].header_keep)
		else $error("set address did not set header keep");
	a_clr_applies: assert property (do_write && wr_dec.hit_rx && wr_dec.clr && wr_bits[`BIT_RUN]
		|=> !ctrl[$past(wr_dec.idx[1:0])].run)
		else $error("clear address did not clear run");
	a_read_answer: assert property (ar_take |=> RVALID)
		else $error("read not answered in one cycle");
	c_rx_write: cover property (do_write && wr_dec.hit_rx ##1 BVALID);
	c_tx_read: cover property (ar_take && rd_dec.hit_tx);

	// a pending write answer must stand and must block new requests until taken
	a_bvalid_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped before taken");
	a_busy_no_take: assert property (BVALID |-> !AWREADY && !WREADY)
		else $error("write request taken with response pending");
	a_rx_wr_okay: assert property (do_write && wr_dec.hit_rx |=> BVALID && BRESP == `RESP_OKAY)
		else $error("control write not answered okay");

	// read answers stand until taken and carry the state seen at the address edge
	a_rvalid_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP))
		else $error("read answer dropped before taken");
	a_unmapped_rd: assert property (ar_take && !rd_dec.hit_tx && !rd_dec.hit_rx |=> RRESP == `RESP_SLVERR)
		else $error("unmapped read not refused");
	a_tx_rd_value: assert property (ar_take && rd_dec.hit_tx |=> RDATA == $past(tx_ptr_reg[rd_dec.idx]))
		else $error("tx pointer read wrong");
	a_rx_rd_run: assert property (ar_take && rd_dec.hit_rx
		|=> RDATA[`BIT_RUN] == $past(ctrl[rd_dec.idx[1:0]].run))
		else $error("run bit read back wrong");
	a_rx_rd_active: assert property (ar_take && rd_dec.hit_rx
		|=> RDATA[`BIT_ACTIVE] == $past(ctrl[rd_dec.idx[1:0]].active))
		else $error("active bit read back wrong");
	a_rx_rd_split: assert property (ar_take && rd_dec.hit_rx
		|=> RDATA[`BIT_SPLIT] == $past(ctrl[rd_dec.idx[1:0]].split))
		else $error("split bit read back wrong");

	// tx pointers follow the load strobe only; bus writes must leave them alone
	a_ptr_no_sw: assert property (!TX_PTR_LOAD[0] |=> $stable(tx_ptr_reg[0]))
		else $error("tx pointer changed without a load");
	a_ptr_loads: assert property (TX_PTR_LOAD[7] |=> tx_ptr_reg[7] == $past(TX_PTR_VALUE))
		else $error("tx pointer load lost");

endmodule : isoch_rx_context_control
`default_nettype wire

// ---- verif/isoch_pkt_source.sv ----
// Purpose: packet source standing in for the link layer
// Assumes: one packet per send pulse
// Notes:   stale data is inverted on every idle cycle, so it matches the last packet again every second idle cycle
`timescale 1ns/1ps
`default_nettype none
module isoch_pkt_source (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// request
	input  wire logic                  send,
	input  wire logic [5:0]            ch,
	input  wire logic [15:0]           st,
	// packet out
	output logic                       pkt_valid,
	output var  isoch_rx_pkg::rx_pkt_t pkt
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pkt_valid <= 1'h0;
			pkt       <= '0;
		end else begin
			pkt_valid <= send;
			pkt       <= send ? {ch, st} : ~pkt;
		end
	end
endmodule : isoch_pkt_source
`default_nettype wire

// ---- verif/isoch_rx_context_control_tb.sv ----
// Purpose: self-checking bench of the context registers and packet routing
// Assumes: bus answers arrive within a few cycles of each request
// Notes:   tx pointer reset taken as zero
`timescale 1ns/1ps
`default_nettype none
module isoch_rx_context_control_tb;
	logic CLK, RSTN, AWVALID, WVALID, BREADY, ARVALID, RREADY, CYC_START, send;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, DELIVER_VALID, PKT_MISS, PKT_VALID;
	logic [11:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, TX_PTR_VALUE, seed, d;
	logic [1:0]  BRESP, RRESP, r;
	logic [7:0]  TX_PTR_LOAD;
	logic [3:0][12:0] MATCH_CYCLE;
	logic [3:0][5:0]  MATCH_CHANNEL;
	logic [63:0] CHAN_MASK;
	logic [2:0]  CYC_SECONDS;
	logic [12:0] CYC_NUMBER;
	logic [5:0]  ch;
	logic [15:0] st;
	isoch_rx_pkg::rx_pkt_t        PKT;
	isoch_rx_pkg::rx_deliver_t    DELIVER;
	isoch_rx_pkg::rx_ctrl_t [3:0] RX_CTRL;
	int fail_count, total_checks, n;
	isoch_rx_context_control uut (.CLK(CLK), .RSTN(RSTN), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.AWADDR(AWADDR), .AWPROT(3'h0), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(4'hf),
		.BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.ARADDR(ARADDR), .ARPROT(3'h0), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
		.TX_PTR_LOAD(TX_PTR_LOAD), .TX_PTR_VALUE(TX_PTR_VALUE), .MATCH_CYCLE(MATCH_CYCLE),
		.MATCH_CHANNEL(MATCH_CHANNEL), .CHAN_MASK(CHAN_MASK), .CYC_START(CYC_START),
		.CYC_SECONDS(CYC_SECONDS), .CYC_NUMBER(CYC_NUMBER), .PKT_VALID(PKT_VALID), .PKT(PKT),
		.DELIVER_VALID(DELIVER_VALID), .DELIVER(DELIVER), .PKT_MISS(PKT_MISS), .RX_CTRL(RX_CTRL));
	isoch_pkt_source src (.clk(CLK), .rst_n(RSTN), .send(send), .ch(ch), .st(st),
		.pkt_valid(PKT_VALID), .pkt(PKT));
	initial begin
		CLK = 1'h0;
		forever #10 CLK = ~CLK;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	task chk(input logic [39:0] g, input logic [39:0] e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task tmo(input int i);
		if (i >= 64) begin
			fail_count++;
			end_of_test();
		end
	endtask : tmo
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		int i;
		@(posedge CLK);
		AWVALID <= 1'h1;
		AWADDR  <= a;
		WVALID  <= 1'h1;
		WDATA   <= v;
		BREADY  <= 1'h1;
		for (i = 0; i < 64; i++) begin
			@(posedge CLK);
			if (AWREADY) AWVALID <= 1'h0;
			if (WREADY) WVALID <= 1'h0;
			if (BVALID) break;
		end
		r = BRESP;
		BREADY <= 1'h0;
		tmo(i);
	endtask : wr
	task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		int i;
		@(posedge CLK);
		ARVALID <= 1'h1;
		ARADDR  <= a;
		RREADY  <= 1'h1;
		for (i = 0; i < 64; i++) begin
			@(posedge CLK);
			if (ARREADY) ARVALID <= 1'h0;
			if (RVALID) break;
		end
		d = RDATA;
		r = RRESP;
		RREADY <= 1'h0;
		tmo(i);
		chk(d, e);
		chk(r, er);
	endtask : rchk
	task automatic cyc(input logic [2:0] s, input logic [12:0] c);
		@(posedge CLK);
		CYC_START   <= 1'h1;
		CYC_SECONDS <= s;
		CYC_NUMBER  <= c;
		@(posedge CLK);
		CYC_START <= 1'h0;
		@(posedge CLK);
	endtask : cyc
	// random status on every packet, wait for delivery or miss
	task automatic pk(input logic [5:0] c);
		int i;
		seed = lfsr(seed);
		@(posedge CLK);
		send <= 1'h1;
		ch   <= c;
		st   <= seed[15:0];
		@(posedge CLK);
		send <= 1'h0;
		for (i = 0; i < 64; i++) begin
			@(posedge CLK);
			if (DELIVER_VALID || PKT_MISS) break;
		end
		tmo(i);
	endtask : pk
	initial begin
		repeat (20000) @(posedge CLK);
		fail_count++;
		end_of_test();
	end
	initial begin
		{AWVALID, WVALID, BREADY, ARVALID, RREADY, CYC_START, send} = 7'h0;
		{AWADDR, ARADDR, WDATA, TX_PTR_VALUE, TX_PTR_LOAD} = '0;
		{MATCH_CYCLE, MATCH_CHANNEL, CHAN_MASK, CYC_SECONDS, CYC_NUMBER, ch, st} = '0;
		RSTN = 1'h0;
		seed = 32'h2ac03068;
		repeat (12) @(posedge CLK);
		RSTN <= 1'h1;
		rchk(12'h400, 32'h0, 2'h0);
		for (n = 0; n < 8; n++) begin
			seed = lfsr(seed);
			@(posedge CLK);
			TX_PTR_LOAD  <= 8'(8'h1 << n);
			TX_PTR_VALUE <= seed;
			@(posedge CLK);
			TX_PTR_LOAD <= 8'h0;
			wr(12'(12'h20c + 16 * n), ~seed);
			chk(r, 2'h2);
			rchk(12'(12'h20c + 16 * n), seed, 2'h0);
		end
		rchk(12'h100, 32'h0, 2'h2);
		// pack and multi given together, as software must, then overridden by split
		wr(12'h460, 32'h9fff_0000);
		rchk(12'h464, 32'h0800_0000, 2'h0);
		wr(12'h460, 32'h0000_8000);
		wr(12'h464, 32'h0800_0000);
		rchk(12'h464, 32'h0800_8400, 2'h0);
		wr(12'h464, 32'h0000_8000);
		rchk(12'h460, 32'h0800_0000, 2'h0);
		MATCH_CYCLE[2] <= 13'h0055;
		wr(12'h440, 32'h2000_8000);
		cyc(3'h1, 13'h0054);
		rchk(12'h440, 32'h2000_8000, 2'h0);
		cyc(3'h1, 13'h0055);
		rchk(12'h440, 32'h0000_8400, 2'h0);
		chk(RX_CTRL[2], 7'h03);
		MATCH_CHANNEL[0] <= 6'h05;
		wr(12'h400, 32'h4000_8000);
		cyc(3'h3, 13'h0123);
		pk(6'h05);
		chk({2'h0, PKT_MISS, DELIVER}, {5'h0, 3'h4, st, 3'h3, 13'h0123});
		pk(6'h06);
		chk({DELIVER_VALID, PKT_MISS}, 2'h1);
		CHAN_MASK <= 64'h200;
		MATCH_CHANNEL[1] <= 6'h0a;
		wr(12'h420, 32'h9000_8000);
		pk(6'h09);
		chk({2'h0, PKT_MISS, DELIVER}, {5'h1, 3'h2, 32'h0});
		pk(6'h0a);
		chk({DELIVER_VALID, PKT_MISS}, 2'h1);
		// split context left over above: run it and route one packet through it
		MATCH_CHANNEL[3] <= 6'h0c;
		wr(12'h460, 32'h0000_8000);
		pk(6'h0c);
		chk({2'h0, PKT_MISS, DELIVER}, {5'h3, 3'h1, 32'h0});
		chk(RX_CTRL[3], 7'h07);
		end_of_test();
	end
endmodule : isoch_rx_context_control_tb
`default_nettype wire
